// [include/dsn_pkg.sv]
// Constants and types for the DAC setting serial slave with non-volatile store
package dsn_pkg;

    // ==========================================================
    // Bus addressing and byte layout
    localparam logic [6:0] DSN_ADDR7     = 7'h4f;  // Address byte 9E/9F with R/W in bit 0
    localparam logic [2:0] DSN_LAST_BIT  = 3'h7;
    localparam logic [2:0] DSN_BIT_ONE   = 3'h1;
    localparam logic       DSN_P_NVM     = 1'b0;   // Write: also store in non-volatile copy
    localparam logic       DSN_RW_READ   = 1'b1;
    localparam logic [7:0] DSN_STEP_ONE  = 8'h01;

    // ==========================================================
    // Reset values
    localparam logic [6:0] DSN_NVM_INIT  = 7'h00;
    localparam logic [3:0] DSN_SYNC_RST  = 4'he;   // Bus lines idle high, protect input low
    localparam int         DSN_I_SCL     = 3;
    localparam int         DSN_I_SDA     = 2;
    localparam int         DSN_I_SCLS    = 1;
    localparam int         DSN_I_WP      = 0;

    // ==========================================================
    // Timing
    localparam int         DSN_CLK_MHZ   = 200;
    localparam int         DSN_BOOT_US   = 30;
    localparam int         DSN_BOOT_CYC  = DSN_BOOT_US * DSN_CLK_MHZ;
    localparam int         DSN_PROG_MS   = 200;
    localparam int         DSN_PROG_CYC  = DSN_PROG_MS * 1000 * DSN_CLK_MHZ;

    // ==========================================================
    // Types
    typedef struct packed {
        logic [6:0] code;
        logic       pbit;
    } dsn_byte_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_AACK = 7'h04,
        ST_RX   = 7'h08,
        ST_RACK = 7'h10,
        ST_TX   = 7'h20,
        ST_TACK = 7'h40
    } dsn_state_t;

endpackage

// [design/dsn_nvm.sv]
// Non-volatile copy of the setting with a timed programming cycle
`timescale 1ns/1ps
module dsn_nvm
    import dsn_pkg::*;
#(
    parameter int PROG_CYC = DSN_PROG_CYC
)
(
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic       wr_in,
    input  wire logic [6:0] wr_data_in,
    output logic      [6:0] rd_data_out,
    output logic            busy_out
);

    logic [6:0]  store_r;
    logic [6:0]  pend_r;
    logic [31:0] cnt_r;

    // ==========================================================
    // Programming cycle
    // New value lands only at the end; a reset mid-cycle loads DSN_NVM_INIT, not the old one
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            store_r  <= DSN_NVM_INIT;
            pend_r   <= DSN_NVM_INIT;
            cnt_r    <= '0;
            busy_out <= 1'b0;
        end
        else if (busy_out)
        begin
            if (cnt_r == 32'(PROG_CYC - 1))
            begin
                store_r  <= pend_r;
                busy_out <= 1'b0;
                cnt_r    <= '0;
            end
            else
            begin
                cnt_r <= cnt_r + 32'h0000_0001;
            end
        end
        else if (wr_in)
        begin
            pend_r   <= wr_data_in;
            busy_out <= 1'b1;
        end
    end

    // ==========================================================
    // Registered read port
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            rd_data_out <= DSN_NVM_INIT;
        end
        else
        begin
            rd_data_out <= store_r;
        end
    end

endmodule

// [design/dsn_slave.sv]
// Serial-bus slave holding a 7-bit DAC setting with non-volatile backup
//
// What this block does
// - Answer only the address byte 9E, bit eight selecting read or write.
// - Slave only: never drives the clock, never starts a transfer.
// - Pull data low in the ninth clock after own address.
// - Acknowledge every data byte received during a write.
// - Code N selects step N+1 of 128.
// - Setting lives in a volatile register, optionally committed to non-volatile store.
// - At start-up copy the stored value into the register.
// - Master may read back the present setting as well as write.
// - Protect input low or open blocks non-volatile programming.
// - Protect input low still lets writes reach the volatile register.
// - Protect input high: program flag chooses register alone or both.
// - Protect input high joins switched clock to the clock line.
// - Protect output is always the inverse of the protect input.
// - Read bit high returns the register, low accepts a new setting.
// - Each data byte is seven setting bits plus one program flag.
// - Flag one writes register only, zero writes register and store.
// - Read flag is one when programming done, zero while busy.
`timescale 1ns/1ps
module dsn_slave
    import dsn_pkg::*;
#(
    parameter int BOOT_CYC = DSN_BOOT_CYC,
    parameter int PROG_CYC = DSN_PROG_CYC
)
(
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic       scl_in,
    input  wire logic       scl_s_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    input  wire logic       wp_n_in,
    output logic            wp_p_out,
    output logic            scl_switch_out,
    output logic      [6:0] dac_code_out,
    output logic      [7:0] dac_step_out,
    output logic            nvm_busy_out,
    output logic            ready_out
);

    logic [3:0]  sync1_r;
    logic [3:0]  sync2_r;
    logic        scl_eff;
    logic        scl_q_r;
    logic        sda_q_r;
    logic        sda_s;
    logic        wp_s;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    dsn_state_t  st_r;
    logic [2:0]  bit_cnt_r;
    logic [7:0]  shift_r;
    logic        got8_r;
    logic        rw_r;
    logic [7:0]  tx_r;
    logic        sda_drv_r;
    dsn_byte_t   rx_byte;
    dsn_byte_t   rd_byte;
    logic        commit;
    logic        nvm_wr;
    logic [6:0]  vol_r;
    logic [31:0] boot_cnt_r;
    logic        booted_r;
    logic [6:0]  nvm_rd;
    logic        nvm_busy;

    // ==========================================================
    // Pin synchronisers
    generate
        for (genvar g = 0; g < 4; g++)
        begin : g_sync
            always_ff @(posedge clk_in or posedge reset_in)
            begin
                if (reset_in)
                begin
                    sync1_r[g] <= DSN_SYNC_RST[g];
                    sync2_r[g] <= DSN_SYNC_RST[g];
                end
                else
                begin
                    sync1_r[g] <= (g == DSN_I_SCL) ? scl_in :
                                  (g == DSN_I_SDA) ? sda_in :
                                  (g == DSN_I_SCLS) ? scl_s_in : wp_n_in;
                    sync2_r[g] <= sync1_r[g];
                end
            end
        end
    endgenerate

    assign sda_s = sync2_r[DSN_I_SDA];
    assign wp_s  = sync2_r[DSN_I_WP];

    // switched clock joining
    // Open switch leaves the clock line alone; closed, the two wire-AND
    assign scl_eff = sync2_r[DSN_I_SCL] & (~wp_s | sync2_r[DSN_I_SCLS]);
    assign scl_switch_out = wp_s;

    assign wp_p_out = ~wp_s;

    // ==========================================================
    // Bus edge and condition detection
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end
        else
        begin
            scl_q_r <= scl_eff;
            sda_q_r <= sda_s;
        end
    end

    assign scl_rise  = scl_eff & ~scl_q_r;
    assign scl_fall  = ~scl_eff & scl_q_r;
    assign start_det = scl_eff & scl_q_r & sda_q_r & ~sda_s;
    assign stop_det  = scl_eff & scl_q_r & ~sda_q_r & sda_s;

    assign rx_byte = dsn_byte_t'(shift_r);
    assign rd_byte = '{code: vol_r, pbit: ~nvm_busy};

    // ==========================================================
    // Protocol engine
    // only the data line is ever driven, and only after a start from outside
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            st_r      <= ST_IDLE;
            bit_cnt_r <= '0;
            shift_r   <= '0;
            got8_r    <= 1'b0;
            rw_r      <= 1'b0;
            tx_r      <= '0;
            sda_drv_r <= 1'b0;
        end
        else if (!booted_r)
        begin
            st_r      <= ST_IDLE;
            sda_drv_r <= 1'b0;
        end
        else if (start_det)
        begin
            st_r      <= ST_ADDR;
            bit_cnt_r <= '0;
            got8_r    <= 1'b0;
            sda_drv_r <= 1'b0;
        end
        else if (stop_det)
        begin
            st_r      <= ST_IDLE;
            sda_drv_r <= 1'b0;
        end
        else
        begin
            unique case (st_r)
                ST_IDLE:
                begin
                    sda_drv_r <= 1'b0;
                end
                ST_ADDR, ST_RX:
                begin
                    if (scl_rise)
                    begin
                        shift_r   <= {shift_r[6:0], sda_s};
                        bit_cnt_r <= bit_cnt_r + DSN_BIT_ONE;
                        if (bit_cnt_r == DSN_LAST_BIT)
                        begin
                            got8_r <= 1'b1;
                        end
                    end
                    else if (scl_fall && got8_r)
                    begin
                        got8_r <= 1'b0;
                        if (st_r == ST_RX)
                        begin
                            st_r      <= ST_RACK;
                            sda_drv_r <= 1'b1;
                        end
                        else if (shift_r[7:1] == DSN_ADDR7)
                        begin
                            st_r      <= ST_AACK;
                            sda_drv_r <= 1'b1;
                            rw_r      <= shift_r[0];
                        end
                        else
                        begin
                            st_r <= ST_IDLE;
                        end
                    end
                end
                ST_AACK:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_r <= '0;
                        if (rw_r == DSN_RW_READ)
                        begin
                            st_r      <= ST_TX;
                            tx_r      <= rd_byte;
                            sda_drv_r <= ~rd_byte[7];
                        end
                        else
                        begin
                            st_r      <= ST_RX;
                            sda_drv_r <= 1'b0;
                        end
                    end
                end
                ST_RACK:
                begin
                    if (scl_fall)
                    begin
                        st_r      <= ST_RX;
                        sda_drv_r <= 1'b0;
                    end
                end
                ST_TX:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_r <= bit_cnt_r + DSN_BIT_ONE;
                        if (bit_cnt_r == DSN_LAST_BIT)
                        begin
                            st_r      <= ST_TACK;
                            sda_drv_r <= 1'b0;
                        end
                        else
                        begin
                            tx_r      <= {tx_r[6:0], 1'b0};
                            sda_drv_r <= ~tx_r[6];
                        end
                    end
                end
                ST_TACK:
                begin
                    if (scl_rise)
                    begin
                        got8_r <= ~sda_s;
                    end
                    else if (scl_fall)
                    begin
                        got8_r <= 1'b0;
                        if (got8_r)
                        begin
                            st_r      <= ST_TX;
                            tx_r      <= rd_byte;
                            sda_drv_r <= ~rd_byte[7];
                        end
                        else
                        begin
                            st_r <= ST_IDLE;
                        end
                    end
                end
                default:
                begin
                    st_r      <= ST_IDLE;
                    sda_drv_r <= 1'b0;
                end
            endcase
        end
    end

    assign sda_out    = 1'b0;
    assign sda_oe_out = sda_drv_r;

    // ==========================================================
    // Setting register and start-up load
    assign commit = booted_r && !start_det && !stop_det && (st_r == ST_RX)
                    && scl_fall && got8_r;

    // store write gated by protect; flag zero asks for store
    // Request during a running cycle is dropped, the register still updates
    assign nvm_wr = commit && (rx_byte.pbit == DSN_P_NVM) && wp_s && !nvm_busy;

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            vol_r      <= DSN_NVM_INIT;
            boot_cnt_r <= '0;
            booted_r   <= 1'b0;
        end
        else if (!booted_r)
        begin
            if (boot_cnt_r == 32'(BOOT_CYC - 1))
            begin
                vol_r    <= nvm_rd;
                booted_r <= 1'b1;
            end
            else
            begin
                boot_cnt_r <= boot_cnt_r + 32'h0000_0001;
            end
        end
        // volatile write whatever the protect level
        else if (commit)
        begin
            vol_r <= rx_byte.code;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            dac_step_out <= DSN_STEP_ONE;
        end
        else
        begin
            dac_step_out <= {1'b0, vol_r} + DSN_STEP_ONE;
        end
    end

    assign dac_code_out = vol_r;
    assign ready_out    = booted_r;
    assign nvm_busy_out = nvm_busy;

    dsn_nvm #(
        .PROG_CYC    (PROG_CYC)
    ) u_nvm (
        .clk_in      (clk_in),
        .reset_in    (reset_in),
        .wr_in       (nvm_wr),
        .wr_data_in  (rx_byte.code),
        .rd_data_out (nvm_rd),
        .busy_out    (nvm_busy)
    );

    // ==========================================================
    // Checks
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);

    addr_match_a: assert property ($rose(st_r == ST_AACK) |->
        $past(shift_r[7:1]) == DSN_ADDR7)
        else $error("acknowledged a foreign address");
    addr_ack_a: assert property (st_r == ST_AACK |-> sda_oe_out)
        else $error("address acknowledge not driven");
    data_ack_a: assert property (commit |=> st_r == ST_RACK && sda_oe_out)
        else $error("data byte not acknowledged");
    drive_only_a: assert property (sda_oe_out |->
        st_r inside {ST_AACK, ST_RACK, ST_TX})
        else $error("data line driven outside slave slots");
    dac_step_a: assert property (##1 dac_step_out == {1'b0, $past(vol_r)} + DSN_STEP_ONE)
        else $error("step is not code plus one");
    vol_write_a: assert property (commit |=> vol_r == $past(rx_byte.code))
        else $error("register missed a write");
    protect_a: assert property (!wp_s && !nvm_busy |=> !nvm_busy)
        else $error("store cycle started while protected");
    nvm_req_a: assert property (commit && !rx_byte.pbit && wp_s && !nvm_busy
        |=> nvm_busy)
        else $error("store request not started");
    boot_load_a: assert property ($rose(booted_r) |-> vol_r == $past(nvm_rd))
        else $error("start-up copy wrong");
    read_byte_a: assert property ($rose(st_r == ST_TX) |->
        tx_r == {$past(vol_r), ~$past(nvm_busy)})
        else $error("read byte wrong");
    switch_a: assert property (scl_switch_out == wp_s && wp_p_out != wp_s)
        else $error("switch or protect output wrong");

    write_cov_c: cover property (commit ##1 st_r == ST_RACK);
    read_cov_c: cover property ($rose(st_r == ST_TX));
    nvm_cov_c: cover property ($rose(nvm_busy));

endmodule

// [tb/dsn_master_model.sv]
// Behavioural two-wire bus master facing the serial slave
`timescale 1ns/1ps
module dsn_master_model
(
    input  wire logic       clk_in,
    input  wire logic       sda_in,
    input  wire logic       use_s_in,
    output logic            scl_out,
    output logic            scl_s_out,
    output logic            sda_oe_out,
    output logic      [7:0] rd_byte_out,
    output logic      [7:0] rd_cnt_out
);
    // ==========================================================
    // Idle lines
    // master owns clocks, unused source parked
    initial
    begin
        scl_out     = 1'b1;
        scl_s_out   = 1'b1;
        sda_oe_out  = 1'b0;
        rd_byte_out = 8'h00;
        rd_cnt_out  = 8'h00;
    end

    // ==========================================================
    // Bit timing, a quarter of 160 ns
    task automatic qtr();
        repeat (8) @(posedge clk_in);
        #1;
    endtask

    task automatic clk_set(input logic v);
        if (use_s_in)
            scl_s_out = v;
        else
            scl_out = v;
    endtask

    task automatic bit_io(input logic b, output logic s);
        sda_oe_out = ~b;
        qtr();
        clk_set(1'b1);
        qtr();
        s = sda_in;
        qtr();
        clk_set(1'b0);
        qtr();
    endtask

    // ==========================================================
    // Framing
    // start only from idle or as a repeated start
    task automatic start_c();
        sda_oe_out = 1'b0;
        qtr();
        clk_set(1'b1);
        qtr();
        sda_oe_out = 1'b1;
        qtr();
        clk_set(1'b0);
        qtr();
    endtask

    // every transfer closed by a stop
    task automatic stop_c();
        sda_oe_out = 1'b1;
        qtr();
        clk_set(1'b1);
        qtr();
        sda_oe_out = 1'b0;
        qtr();
    endtask

    // eight bits then the acknowledge clock
    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    task automatic recv(input logic mack);
        logic [7:0] b;
        logic       s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, s);
            b[i] = s;
        end
        bit_io(~mack, s);
        rd_byte_out = b;
        rd_cnt_out  = rd_cnt_out + 8'h01;
    endtask
endmodule

// [tb/dsn_slave_tb_top.sv]
// Self-checking bench for the serial DAC setting slave
`timescale 1ns/1ps
module dsn_slave_tb_top;
    import dsn_pkg::*;
    // Short counts keep the run brief
    localparam int BOOT = 20;
    localparam int PROG = 2000;
    logic       clk_in;
    logic       reset_in;
    logic       wp_n_in;
    logic       use_s;
    logic       m_scl;
    logic       m_scl_s;
    logic       m_oe;
    logic       d_out;
    logic       d_oe;
    logic       wp_p;
    logic       sw;
    logic       busy;
    logic       ready;
    logic [6:0] code;
    logic [7:0] step;
    logic [7:0] rd_byte;
    logic [7:0] rd_cnt;
    logic [6:0] c;
    logic [7:0] ab;
    logic       a;
    logic [31:0] rnd;
    logic [7:0] exp_q[$];
    int         err_count;
    int         comparisons;
    wire        sda_w = ~(m_oe | (d_oe & ~d_out));

    dsn_slave #(.BOOT_CYC(BOOT), .PROG_CYC(PROG)) dsn_slave_inst
    (
        .clk_in(clk_in), .reset_in(reset_in), .scl_in(m_scl), .scl_s_in(m_scl_s),
        .sda_in(sda_w), .sda_out(d_out), .sda_oe_out(d_oe), .wp_n_in(wp_n_in),
        .wp_p_out(wp_p), .scl_switch_out(sw), .dac_code_out(code), .dac_step_out(step),
        .nvm_busy_out(busy), .ready_out(ready)
    );

    dsn_master_model dsn_master_model_inst
    (
        .clk_in(clk_in), .sda_in(sda_w), .use_s_in(use_s), .scl_out(m_scl),
        .scl_s_out(m_scl_s), .sda_oe_out(m_oe), .rd_byte_out(rd_byte), .rd_cnt_out(rd_cnt)
    );

    // ==========================================================
    // Clock and helpers
    initial
    begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Second data byte, when asked, overwrites the first
    task automatic wr(input logic [6:0] cv, input logic p, input logic ea, input int n);
        logic k;
        dsn_master_model_inst.start_c();
        dsn_master_model_inst.send({DSN_ADDR7, ~DSN_RW_READ}, k);
        chk("address ack", {7'h00, ea}, {7'h00, k});
        if (k === 1'b1)
        begin
            for (int i = n; i > 0; i--)
            begin
                dsn_master_model_inst.send({cv ^ ((i > 1) ? 7'h55 : 7'h00), p}, k);
                chk("data ack", 8'h01, {7'h00, k});
            end
        end
        dsn_master_model_inst.stop_c();
    endtask

    task automatic rd(input logic [7:0] e, input int n);
        logic k;
        dsn_master_model_inst.start_c();
        dsn_master_model_inst.send({DSN_ADDR7, DSN_RW_READ}, k);
        chk("read address ack", 8'h01, {7'h00, k});
        for (int i = 0; i < n; i++)
        begin
            exp_q.push_back(e);
            dsn_master_model_inst.recv(i < n - 1);
        end
        dsn_master_model_inst.stop_c();
    endtask

    task automatic chk_code(input logic [6:0] e);
        chk("code", {1'b0, e}, {1'b0, code});
        chk("step", {1'b0, e} + 8'h01, step);
    endtask

    // ==========================================================
    // Read results against the oldest note
    always @(rd_cnt)
    begin
        if (reset_in === 1'b0)
        begin
            if (exp_q.size() == 0)
                chk("unexpected read", 8'h00, 8'hff);
            else
                chk("read byte", exp_q.pop_front(), rd_byte);
        end
    end

    // Limit well above the expected span of the sequence
    initial
    begin
        #400000;
        err_count++;
        report_and_stop();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        err_count   = 0;
        comparisons = 0;
        reset_in    = 1'b1;
        wp_n_in     = 1'b0;
        use_s       = 1'b0;
        rnd         = 32'h2693_8904;
        repeat (2) @(posedge clk_in);
        #1;
        reset_in = 1'b0;
        chk_code(7'h00);
        chk("ready early", 8'h00, {7'h00, ready});
        chk("protect out", 8'h01, {7'h00, wp_p});
        chk("switch open", 8'h00, {7'h00, sw});
        for (int n = 0; n < 100 && ready !== 1'b1; n++)
            @(posedge clk_in);
        #1;
        chk("ready", 8'h01, {7'h00, ready});
        chk_code(DSN_NVM_INIT);
        repeat (4) @(posedge clk_in);
        #1;
        // Foreign addresses stay unanswered
        for (int k = 0; k < 4; k++)
        begin
            rnd = lfsr(rnd);
            ab  = rnd[7:0];
            if (ab[7:1] == DSN_ADDR7)
                ab[7] = ~ab[7];
            dsn_master_model_inst.start_c();
            dsn_master_model_inst.send(ab, a);
            chk("foreign ack", 8'h00, {7'h00, a});
            dsn_master_model_inst.stop_c();
        end
        // Protected: both flags reach the register only
        for (int k = 0; k < 4; k++)
        begin
            rnd = lfsr(rnd);
            c   = rnd[6:0];
            wr(c, k[0], 1'b1, 1 + k[1]);
            chk_code(c);
            chk("busy protected", 8'h00, {7'h00, busy});
            rd({c, 1'b1}, 2);
        end
        // Store enabled
        wp_n_in = 1'b1;
        repeat (4) @(posedge clk_in);
        #1;
        chk("protect out", 8'h00, {7'h00, wp_p});
        chk("switch closed", 8'h01, {7'h00, sw});
        rnd = lfsr(rnd);
        c   = rnd[6:0];
        wr(c, DSN_P_NVM, 1'b1, 1);
        chk_code(c);
        chk("busy", 8'h01, {7'h00, busy});
        rd({c, 1'b0}, 1);
        for (int n = 0; n < 3000 && busy !== 1'b0; n++)
            @(posedge clk_in);
        #1;
        chk("busy done", 8'h00, {7'h00, busy});
        rd({c, 1'b1}, 1);
        wr(~c, 1'b1, 1'b1, 1);
        chk("busy reg only", 8'h00, {7'h00, busy});
        chk_code(~c);
        // Switched clock joined, then opened
        use_s = 1'b1;
        rnd   = lfsr(rnd);
        c     = rnd[6:0];
        wr(c, 1'b1, 1'b1, 1);
        chk_code(c);
        wp_n_in = 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
        wr(~c, 1'b1, 1'b0, 1);
        chk_code(c);
        use_s = 1'b0;
        rd({c, 1'b1}, 1);
        report_and_stop();
    end
endmodule
